// ==== common/ims_pkg.sv ====
// constants, register map and state type for the two-wire master sequencer
package ims_pkg;
	// system clock and the serial clock rates; only the fast and fast-plus reloads fit in RELOAD_W bits
	localparam int CLK_HZ = 50_000_000;
	localparam int SCL_STD_HZ = 100_000;
	localparam int SCL_FAST_HZ = 400_000;
	localparam int SCL_FASTP_HZ = 1_000_000;
	// reload value giving one half period of the serial clock
	localparam int RLD_STD = CLK_HZ / (2 * SCL_STD_HZ) - 1;
	localparam int RLD_FAST = CLK_HZ / (2 * SCL_FAST_HZ) - 1;
	localparam int RLD_FASTP = CLK_HZ / (2 * SCL_FASTP_HZ) - 1;
	// widths
	localparam int RELOAD_W = 7;
	localparam int ADDR_W = 2;
	localparam int DATA_W = 8;
	// register offsets
	localparam logic [1:0] A_CTRL2 = 2'h0;
	localparam logic [1:0] A_STAT = 2'h1;
	localparam logic [1:0] A_BUF = 2'h2;
	localparam logic [1:0] A_RATE = 2'h3;
	// second control register fields
	localparam int B_START = 0;
	localparam int B_RSTART = 1;
	localparam int B_STOP = 2;
	localparam int B_RCV = 3;
	localparam int B_ACKDT = 5;
	localparam int B_ACKST = 6;
	// status register fields
	localparam int B_IRQ = 0;
	localparam int B_BCOL = 1;
	localparam int B_BUSY = 2;
	// reset value of the rate reload field
	localparam logic [6:0] RATE_RST = 7'h18;
	// sequencer states
	typedef enum logic [3:0] {
		ST_IDLE, ST_START, ST_BIT_LO, ST_BIT_HI,
		ST_SP_LOW, ST_SP_RISE, ST_SP_REL,
		ST_RS_REL, ST_RS_RISE, ST_RS_HIGH, ST_RS_LOW
	} ims_state_t;
endpackage

// ==== logic/ims_master.sv ====
// two-wire master sequencer: start, stop, repeated start and byte shifter
//
// The register offsets and the address-and-strobe port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module ims_master #(
	parameter int RELOAD_W = ims_pkg::RELOAD_W
) (
	input wire logic mclk,
	input wire logic reset_n,
	input wire logic [ims_pkg::ADDR_W-1:0] reg_addr,
	input wire logic [ims_pkg::DATA_W-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [ims_pkg::DATA_W-1:0] reg_rdata,
	input wire logic scl_i,
	output logic scl_o,
	output logic scl_oe,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe
);

	typedef struct packed {
		ims_pkg::ims_state_t st;
		logic [RELOAD_W-1:0] rate_counter;
		logic [RELOAD_W-1:0] reload;
		logic [8:0] sh;
		logic [3:0] bitcnt;
		logic rcv;
		logic [7:0] rbuf;
		logic req_start;
		logic req_rstart;
		logic req_stop;
		logic req_rcv;
		logic ack_data;
		logic ack_stat;
		logic irq;
		logic bcol;
		logic scl_m;
		logic scl_s;
		logic sda_m;
		logic sda_s;
		logic scl_oe;
		logic sda_oe;
		logic lvl;
		logic [7:0] rdata;
	} ims_regs_t;

	ims_regs_t q;
	ims_regs_t d;
	ims_pkg::ims_state_t nst;
	logic tick;
	logic hi_tick;
	logic cnt_en;
	logic set_irq;
	logic set_bcol;
	logic buf_wr;

	// address match of one strobe
	function automatic logic hit(
		input logic stb,
		input logic [ims_pkg::ADDR_W-1:0] a,
		input logic [ims_pkg::ADDR_W-1:0] c
	);
		return stb && (a == c);
	endfunction

	// rate counter expiry, and expiry only while the clock reads high
	assign tick = (q.rate_counter == '0);
	assign hi_tick = tick && q.scl_s;
	assign buf_wr = hit(reg_wr, reg_addr, ims_pkg::A_BUF);

	// next state of the whole block
	always_comb begin
		d = q;
		nst = q.st;
		cnt_en = 1'b1;
		set_irq = 1'b0;
		set_bcol = 1'b0;
		d.rdata = '0;
		// two-stage synchronisers on the bus lines
		d.scl_m = scl_i;
		d.scl_s = q.scl_m;
		d.sda_m = sda_i;
		d.sda_s = q.sda_m;
		case (q.st)
			ims_pkg::ST_IDLE: begin
				cnt_en = 1'b0;
				if (q.req_stop && q.scl_oe) begin
					d.sda_oe = 1'b1;
					nst = ims_pkg::ST_SP_LOW;
				end else if (q.req_rstart && q.scl_oe) begin
					d.sda_oe = 1'b0;
					nst = ims_pkg::ST_RS_REL;
				end else if (q.req_start && !q.scl_oe) begin
					d.sda_oe = 1'b1;
					nst = ims_pkg::ST_START;
				end else if (q.req_rcv && q.scl_oe) begin
					d.sh = {8'hff, q.ack_data};
					d.rcv = 1'b1;
					d.bitcnt = '0;
					nst = ims_pkg::ST_BIT_LO;
				end else if (buf_wr && q.scl_oe) begin
					d.sh = {reg_wdata, 1'b1};
					d.rcv = 1'b0;
					d.bitcnt = '0;
					nst = ims_pkg::ST_BIT_LO;
				end
				// accepted or not, pending requests are consumed here
				if (q.req_stop || q.req_rstart || q.req_start || q.req_rcv) begin
					d.req_stop = 1'b0;
					d.req_rstart = 1'b0;
					d.req_start = 1'b0;
					d.req_rcv = 1'b0;
				end
			end
			ims_pkg::ST_START: begin
				// data low with clock high, held one count as start hold
				if (tick) begin
					d.scl_oe = 1'b1;
					set_irq = 1'b1;
					nst = ims_pkg::ST_IDLE;
				end
			end
			ims_pkg::ST_BIT_LO: begin
				// clock low: present the next bit, released for a one
				d.sda_oe = ~q.sh[8];
				if (tick) begin
					d.scl_oe = 1'b0;
					nst = ims_pkg::ST_BIT_HI;
				end
			end
			ims_pkg::ST_BIT_HI: begin
				// clock released; count only once it reads high
				cnt_en = q.scl_s;
				if (hi_tick) begin
					d.sh = {q.sh[7:0], q.sda_s};
					d.scl_oe = 1'b1;
					if (q.bitcnt == 4'd8) begin
						d.rbuf = q.sh[7:0];
						if (!q.rcv) begin
							d.ack_stat = q.sda_s;
						end
						// data held while the clock falls; the next state moves it
						set_irq = 1'b1;
						nst = ims_pkg::ST_IDLE;
					end else begin
						d.bitcnt = q.bitcnt + 4'd1;
						nst = ims_pkg::ST_BIT_LO;
					end
				end
			end
			ims_pkg::ST_SP_LOW: begin
				if (tick) begin
					d.scl_oe = 1'b0;
					nst = ims_pkg::ST_SP_RISE;
				end
			end
			ims_pkg::ST_SP_RISE: begin
				cnt_en = q.scl_s;
				if (hi_tick) begin
					d.sda_oe = 1'b0;
					nst = ims_pkg::ST_SP_REL;
				end
			end
			ims_pkg::ST_SP_REL: begin
				// bus free time passes before the flag
				if (tick) begin
					set_irq = 1'b1;
					nst = ims_pkg::ST_IDLE;
				end
			end
			ims_pkg::ST_RS_REL: begin
				// data released, clock still low
				if (tick) begin
					d.scl_oe = 1'b0;
					nst = ims_pkg::ST_RS_RISE;
				end
			end
			ims_pkg::ST_RS_RISE: begin
				cnt_en = 1'b0;
				if (q.scl_s && !q.sda_s) begin
					set_bcol = 1'b1;
				end else if (q.scl_s) begin
					nst = ims_pkg::ST_RS_HIGH;
				end
			end
			ims_pkg::ST_RS_HIGH: begin
				// a data fall from elsewhere here is tolerated
				if (!q.scl_s && q.sda_s) begin
					set_bcol = 1'b1;
				end else if (tick || !q.sda_s) begin
					d.sda_oe = 1'b1;
					nst = ims_pkg::ST_RS_LOW;
				end
			end
			ims_pkg::ST_RS_LOW: begin
				if (tick) begin
					d.scl_oe = 1'b1;
					set_irq = 1'b1;
					nst = ims_pkg::ST_IDLE;
				end
			end
			default: begin
				nst = ims_pkg::ST_IDLE;
			end
		endcase
		// collision: let go of the bus and give up the sequence
		if (set_bcol) begin
			d.scl_oe = 1'b0;
			d.sda_oe = 1'b0;
			nst = ims_pkg::ST_IDLE;
		end
		// each state entry reloads the rate counter
		if (nst != q.st) begin
			d.st = nst;
			d.rate_counter = q.reload;
		end else if (cnt_en && !tick) begin
			d.rate_counter = q.rate_counter - 1'b1;
		end
		// register writes; requests written now beat the consume above
		if (hit(reg_wr, reg_addr, ims_pkg::A_CTRL2)) begin
			d.req_start = reg_wdata[ims_pkg::B_START];
			d.req_rstart = reg_wdata[ims_pkg::B_RSTART];
			d.req_stop = reg_wdata[ims_pkg::B_STOP];
			d.req_rcv = reg_wdata[ims_pkg::B_RCV];
			d.ack_data = reg_wdata[ims_pkg::B_ACKDT];
		end
		if (hit(reg_wr, reg_addr, ims_pkg::A_STAT)) begin
			if (reg_wdata[ims_pkg::B_IRQ]) begin
				d.irq = 1'b0;
			end
			if (reg_wdata[ims_pkg::B_BCOL]) begin
				d.bcol = 1'b0;
			end
		end
		if (hit(reg_wr, reg_addr, ims_pkg::A_RATE)) begin
			d.reload = reg_wdata[RELOAD_W-1:0];
		end
		// hardware events win over a clear in the same cycle
		if (set_irq) begin
			d.irq = 1'b1;
		end
		if (set_bcol) begin
			d.bcol = 1'b1;
		end
		// read data for the cycle after the strobe
		if (hit(reg_rd, reg_addr, ims_pkg::A_CTRL2)) begin
			d.rdata[ims_pkg::B_START] = q.req_start;
			d.rdata[ims_pkg::B_RSTART] = q.req_rstart;
			d.rdata[ims_pkg::B_STOP] = q.req_stop;
			d.rdata[ims_pkg::B_RCV] = q.req_rcv;
			d.rdata[ims_pkg::B_ACKDT] = q.ack_data;
			d.rdata[ims_pkg::B_ACKST] = q.ack_stat;
		end
		if (hit(reg_rd, reg_addr, ims_pkg::A_STAT)) begin
			d.rdata[ims_pkg::B_IRQ] = q.irq;
			d.rdata[ims_pkg::B_BCOL] = q.bcol;
			d.rdata[ims_pkg::B_BUSY] = (q.st != ims_pkg::ST_IDLE);
		end
		if (hit(reg_rd, reg_addr, ims_pkg::A_BUF)) begin
			d.rdata = q.rbuf;
		end
		if (hit(reg_rd, reg_addr, ims_pkg::A_RATE)) begin
			d.rdata = 8'(q.reload);
		end
	end

	// state register; lines idle high after reset
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			q <= '0;
			q.reload <= RELOAD_W'(ims_pkg::RATE_RST);
			q.scl_m <= 1'b1;
			q.scl_s <= 1'b1;
			q.sda_m <= 1'b1;
			q.sda_s <= 1'b1;
		end else begin
			q <= d;
		end
	end

	// outputs straight from flops; open-drain drive level is low
	assign reg_rdata = q.rdata;
	assign scl_oe = q.scl_oe;
	assign sda_oe = q.sda_oe;
	assign scl_o = q.lvl;
	assign sda_o = q.lvl;

	// checks on the sequencer
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!reset_n);

	sequence s_byte_end;
		q.st == ims_pkg::ST_BIT_HI && hi_tick && q.bitcnt == 4'd8;
	endsequence

	sequence s_rs_expire;
		q.st == ims_pkg::ST_RS_HIGH && tick && q.scl_s && q.sda_s;
	endsequence

	a_start_lines: assert property (
		q.st == ims_pkg::ST_START |-> q.sda_oe && !q.scl_oe)
		else $error("start must hold data low with clock released");

	a_start_hold: assert property (
		q.st == ims_pkg::ST_START && !tick |=> q.st == ims_pkg::ST_START)
		else $error("start left before hold count ended");

	a_byte_flag: assert property (
		s_byte_end |=> q.irq && q.st == ims_pkg::ST_IDLE)
		else $error("flag not set after ninth clock");

	a_ack_store: assert property (
		s_byte_end and !q.rcv |=> q.ack_stat == $past(q.sda_s))
		else $error("acknowledge not stored");

	a_bit_drive: assert property (
		q.st == ims_pkg::ST_BIT_HI |-> q.sda_oe == !q.sh[8])
		else $error("data line does not match shifted bit");

	a_ack_send: assert property (
		q.st == ims_pkg::ST_BIT_HI && q.rcv && q.bitcnt == 4'd8
		|-> q.sda_oe == !q.ack_data)
		else $error("receive acknowledge not driven");

	a_stop_done: assert property (
		q.st == ims_pkg::ST_SP_REL && tick
		|=> q.irq && !q.sda_oe && !q.scl_oe)
		else $error("stop completion wrong");

	a_rs_low_col: assert property (
		q.st == ims_pkg::ST_RS_RISE && q.scl_s && !q.sda_s
		|=> q.bcol && q.st == ims_pkg::ST_IDLE)
		else $error("missed collision on data low");

	a_rs_scl_col: assert property (
		q.st == ims_pkg::ST_RS_HIGH && !q.scl_s && q.sda_s |=> q.bcol)
		else $error("missed collision on early clock fall");

	a_rs_reload: assert property (
		q.st != $past(q.st) && q.st != ims_pkg::ST_IDLE |-> q.rate_counter == q.reload)
		else $error("rate counter not reloaded");

	a_rs_sda_fall: assert property (
		q.st == ims_pkg::ST_RS_HIGH && q.scl_s && !q.sda_s
		|=> q.st == ims_pkg::ST_RS_LOW && !$rose(q.bcol))
		else $error("data fall in high count taken as collision");

	a_rs_drive: assert property (
		s_rs_expire |=> q.st == ims_pkg::ST_RS_LOW && q.sda_oe)
		else $error("data not driven low at count end");

	a_rs_done: assert property (
		q.st == ims_pkg::ST_RS_LOW && tick
		|=> q.scl_oe && q.irq && q.st == ims_pkg::ST_IDLE)
		else $error("repeated start did not complete");

	a_col_release: assert property (
		$rose(q.bcol) |-> !q.scl_oe && !q.sda_oe && q.st == ims_pkg::ST_IDLE)
		else $error("collision did not release the bus");

endmodule // ims_master
`default_nettype wire

// ==== bench/ims_slave.sv ====
// behavioural two-wire slave that answers the master sequencer
`timescale 1ns/1ps
`default_nettype none
module ims_slave #(
	parameter logic [6:0] ADDR = 7'h2a,
	parameter logic [7:0] TX = 8'h96
) (
	input wire logic scl,
	input wire logic sda,
	output logic sda_oe
);
	logic [7:0] sr;
	logic act, first, rd, hit, mack;
	int n;
	initial begin
		sda_oe = 1'b0;
		act = 1'b0;
		hit = 1'b0;
		sr = 8'h00;
		n = 0;
	end
	// start or repeated start: data falls while the clock is high
	always @(negedge sda) begin
		if (scl === 1'b1) begin
			act = 1'b1;
			first = 1'b1;
			rd = 1'b0;
			n = 0;
		end
	end
	// stop: data rises while the clock is high, line let go
	always @(posedge sda) begin
		if (scl === 1'b1) begin
			act = 1'b0;
			sda_oe = 1'b0;
		end
	end
	// data bits and the ninth bit taken at the clock rise
	always @(posedge scl) begin
		if (act && n < 9) begin
			if (n == 8) mack = sda;
			else sr = {sr[6:0], sda};
			n = n + 1;
		end
	end
	// the line only changes while the clock is low
	always @(negedge scl) begin
		if (act && n == 8) begin
			if (first) begin
				rd = sr[0];
				hit = sr[7:1] == ADDR;
				first = 1'b0;
				sda_oe = hit;
			end else sda_oe = hit && !rd;
		end else if (act && n == 9) begin
			n = 0;
			sda_oe = rd && hit && !mack && !TX[7];
		end else if (act && rd && hit && n > 0) sda_oe = !TX[7 - n];
	end
endmodule // ims_slave
`default_nettype wire

// ==== bench/tb.sv ====
// self-checking bench for the two-wire master sequencer
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic mclk, reset_n, reg_wr, reg_rd, scl_oe, sda_oe, s_sda_oe, x_scl_oe, x_sda_oe, arm;
	logic arm_sda, scl_lv, sda_lv;
	logic [1:0] reg_addr;
	logic [7:0] reg_wdata, reg_rdata, rd_v;
	logic [8:0] mon_sr;
	int mon_n, mon_st, mon_sp, err_total, checks_done;
	// wired-and lines with pull-ups
	wire logic scl = !(scl_oe | x_scl_oe);
	wire logic sda = !(sda_oe | s_sda_oe | x_sda_oe);
	ims_master ims_master_inst (.mclk(mclk), .reset_n(reset_n), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.scl_i(scl), .scl_o(scl_lv), .scl_oe(scl_oe),
		.sda_i(sda), .sda_o(sda_lv), .sda_oe(sda_oe));
	ims_slave ims_slave_inst (.scl(scl), .sda(sda), .sda_oe(s_sda_oe));
	// 50 MHz system clock
	initial begin
		mclk = 1'b0;
		forever #10 mclk = ~mclk;
	end
	// line monitor: bits at the clock rise, start and stop conditions
	always @(posedge scl) begin
		mon_sr = {mon_sr[7:0], sda};
		mon_n = mon_n + 1;
	end
	always @(negedge sda) if (scl) mon_st = mon_st + 1;
	always @(posedge sda) if (scl) mon_sp = mon_sp + 1;
	// another master pulls the clock or the data low during the repeated start high count
	always @(posedge scl) begin
		if (arm || arm_sda) begin
			repeat (3) @(posedge mclk);
			if (arm) x_scl_oe <= 1'b1;
			else x_sda_oe <= 1'b1;
		end
	end
	task automatic wr(input logic [1:0] a, input logic [7:0] d);
		@(posedge mclk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge mclk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [1:0] a);
		@(posedge mclk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge mclk);
		reg_rd <= 1'b0;
		#1 rd_v = reg_rdata;
	endtask
	task automatic check(input logic [8:0] got, input logic [8:0] exp);
		checks_done++;
		if (got !== exp) begin
			err_total++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	// one request, bounded wait for done or collision, status compared and cleared
	task automatic step(input logic [1:0] a, input logic [7:0] d, input logic [7:0] st);
		int i;
		mon_n = 0;
		wr(a, d);
		rd_v = 8'h00;
		for (i = 0; i < 400 && rd_v[1:0] == 2'b00; i++) rd(ims_pkg::A_STAT);
		check({1'b0, rd_v}, {1'b0, st});
		wr(ims_pkg::A_STAT, 8'h03);
	endtask
	// one sent byte: wire bits, nine clocks, stored acknowledge
	task automatic tx(input logic [7:0] d, input logic ack);
		step(ims_pkg::A_BUF, d, 8'h01);
		check(mon_sr, {d, ack});
		check(9'(mon_n), 9'd9);
		rd(ims_pkg::A_CTRL2);
		check({1'b0, rd_v}, {2'b00, ack, 6'h00});
	endtask
	task automatic complete_run;
		$display("comparisons %0d mismatches %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	// watchdog well beyond the expected run
	initial begin
		#400000;
		err_total++;
		complete_run();
	end
	initial begin
		{reset_n, reg_wr, reg_rd, x_scl_oe, x_sda_oe, arm} = 6'h00;
		arm_sda = 1'b0;
		{reg_addr, reg_wdata, mon_sr, mon_n, mon_st, mon_sp} = '0;
		{err_total, checks_done} = '0;
		repeat (8) @(posedge mclk);
		reset_n <= 1'b1;
		// lines settle from unknown at time zero; count conditions from here
		mon_st = 0;
		mon_sp = 0;
		rd(ims_pkg::A_RATE);
		check({1'b0, rd_v}, 9'h018);
		check({7'h00, scl_lv, sda_lv}, 9'h000);
		wr(ims_pkg::A_RATE, 8'h03); // 200 ns serial clock: 80 ns low, 120 ns high
		$display("test reset values done");
		step(ims_pkg::A_CTRL2, 8'h01, 8'h01);
		check({7'h00, scl_oe, sda_oe}, 9'h003);
		check(9'(mon_st), 9'd1);
		tx(8'h54, 1'b0);
		tx(8'ha5, 1'b0);
		$display("test write transfer done");
		step(ims_pkg::A_CTRL2, 8'h02, 8'h01);
		check({8'h00, scl_oe}, 9'h001);
		check(9'(mon_st), 9'd2);
		tx(8'h55, 1'b0);
		step(ims_pkg::A_CTRL2, 8'h08, 8'h01);
		check(mon_sr, {8'h96, 1'b0});
		rd(ims_pkg::A_BUF);
		check({1'b0, rd_v}, 9'h096);
		step(ims_pkg::A_CTRL2, 8'h28, 8'h01);
		check(mon_sr, {8'h96, 1'b1});
		step(ims_pkg::A_CTRL2, 8'h04, 8'h01);
		check(9'(mon_sp), 9'd1);
		check({7'h00, scl_oe, sda_oe}, 9'h000);
		$display("test read transfer done");
		step(ims_pkg::A_CTRL2, 8'h01, 8'h01);
		tx(8'h20, 1'b1);
		x_sda_oe <= 1'b1;
		step(ims_pkg::A_CTRL2, 8'h02, 8'h02);
		check({7'h00, scl_oe, sda_oe}, 9'h000);
		x_sda_oe <= 1'b0;
		step(ims_pkg::A_CTRL2, 8'h01, 8'h01);
		arm = 1'b1;
		step(ims_pkg::A_CTRL2, 8'h02, 8'h02);
		arm = 1'b0;
		check({7'h00, scl_oe, sda_oe}, 9'h000);
		x_scl_oe <= 1'b0;
		step(ims_pkg::A_CTRL2, 8'h01, 8'h01);
		arm_sda = 1'b1;
		step(ims_pkg::A_CTRL2, 8'h02, 8'h01);
		arm_sda = 1'b0;
		x_sda_oe <= 1'b0;
		check({7'h00, scl_oe, sda_oe}, 9'h003);
		step(ims_pkg::A_CTRL2, 8'h04, 8'h01);
		$display("test collisions done");
		complete_run();
	end
endmodule // tb
`default_nettype wire
